// file: pkg/adp_consts.svh
`ifndef ADP_CONSTS_SVH
`define ADP_CONSTS_SVH
`define ADP_BUS_WIDTH 16
`define ADP_CLK_FREQ_KHZ 25000
`define ADP_REQ_MAX_FREQ_KHZ 12288
// least half period of the request line in clock cycles, rounded up
`define ADP_REQ_HALF_CYCLES ((`ADP_CLK_FREQ_KHZ + 2 * `ADP_REQ_MAX_FREQ_KHZ - 1) / (2 * `ADP_REQ_MAX_FREQ_KHZ))
`define ADP_BIG_FIFO_QUADLETS 532
`define ADP_SMALL_FIFO_QUADLETS 12
`define ADP_MAX_PAYLOAD_BYTES 1024
`define ADP_LINK_FIFO_DEPTH 4
`define ADP_WIDE_RESET 1'b1
`endif

// file: pkg/adp_pkg.sv
package adp_pkg;
    typedef enum logic [1:0] {
        ADP_IDLE,
        ADP_TX,
        ADP_RX
    } adp_dir_type;
    typedef enum logic [1:0] {
        ADP_PH_IDLE,
        ADP_PH_REQ,
        ADP_PH_XFER,
        ADP_PH_HOLD
    } adp_phase_type;
endpackage

// file: pkg/adp_link_if.sv
`timescale 1ns/100ps
interface adp_link_if;
    logic [15:0] dev_data_out;
    logic dev_data_oe_n;
    logic [15:0] peer_data_out;
    logic peer_data_oe_n;
    logic transport_data_request;
    logic transport_request_ack_n;
    logic transport_write_strobe_n;
    logic transport_read_strobe_n;
    logic [15:0] transport_data_bus;
    assign transport_data_bus = !dev_data_oe_n ? dev_data_out :
        (!peer_data_oe_n ? peer_data_out : 16'h0000);
    modport device (
        input transport_data_bus,
        output dev_data_out,
        output dev_data_oe_n,
        output transport_data_request,
        input transport_request_ack_n,
        input transport_write_strobe_n,
        input transport_read_strobe_n
    );
    modport peer (
        input transport_data_bus,
        output peer_data_out,
        output peer_data_oe_n,
        input transport_data_request,
        output transport_request_ack_n,
        output transport_write_strobe_n,
        output transport_read_strobe_n
    );
endinterface

// file: verilog/adp_fifo.sv
`timescale 1ns/100ps
module adp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign in_ready = (cnt_r != ($clog2(DEPTH+1))'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign level = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (flush) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= bump(wr_r);
            end
            if (pop) begin
                rd_r <= bump(rd_r);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// file: verilog/adp_device_port.sv
`timescale 1ns/100ps
`include "adp_consts.svh"
module adp_device_port #(
    parameter int LINK_DEPTH = `ADP_LINK_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic reset_n,
    adp_link_if.device link,
    input wire logic transport_width_wide_select,
    input wire logic pipe_start,
    input wire logic pipe_dir_rx,
    input wire logic pipe_stop,
    output logic pipe_busy_r,
    output logic pipe_dir_rx_r,
    output logic [15:0] pipe_tx_word_r,
    output logic pipe_tx_valid_r,
    input wire logic pipe_tx_ready,
    input wire logic [15:0] pipe_rx_word,
    input wire logic pipe_rx_valid,
    output logic pipe_rx_ready_r,
    output logic wide_r
);
    import adp_pkg::*;
    localparam int HALF = `ADP_REQ_HALF_CYCLES;
    // packet buffers and the packetiser sit beyond the pipe ports; these bound what they stage
    localparam int BIG_FIFO_WORDS = `ADP_BIG_FIFO_QUADLETS * 2;
    localparam int SMALL_FIFO_WORDS = `ADP_SMALL_FIFO_QUADLETS * 2;
    localparam int MAX_PAYLOAD_WORDS = `ADP_MAX_PAYLOAD_BYTES / 2;

    adp_phase_type phase_r;
    logic [3:0] pace_r;
    logic [15:0] dout_r;
    logic oe_n_r;
    logic req_r;
    logic wr_d_r;
    logic rd_d_r;
    logic lo_half_r;
    logic [7:0] lo_byte_r;
    logic [7:0] rx_hi_r;
    logic hi_pend_r;
    logic [15:0] txf_in;
    logic txf_in_valid;
    logic txf_in_ready;
    logic [15:0] txf_out;
    logic txf_out_valid;
    logic [15:0] rxf_out;
    logic rxf_out_valid;
    logic rxf_in_ready;
    logic rxf_pop;
    logic [$clog2(LINK_DEPTH+1)-1:0] rxf_level;
    logic wr_edge;
    logic rd_edge;
    logic can_serve;

    assign link.dev_data_out = dout_r;
    assign link.dev_data_oe_n = oe_n_r;
    assign link.transport_data_request = req_r;

    // strobes are active low; a word or byte moves on the rising edge
    assign wr_edge = link.transport_write_strobe_n && !wr_d_r;
    assign rd_edge = link.transport_read_strobe_n && !rd_d_r;

    // width and direction latched only between runs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wide_r <= `ADP_WIDE_RESET;
            pipe_dir_rx_r <= 1'b0;
            pipe_busy_r <= 1'b0;
        end else if (!pipe_busy_r && pipe_start) begin
            wide_r <= transport_width_wide_select;
            pipe_dir_rx_r <= pipe_dir_rx;
            pipe_busy_r <= 1'b1;
        end else if (pipe_busy_r && pipe_stop) begin
            pipe_busy_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_d_r <= 1'b1;
            rd_d_r <= 1'b1;
        end else begin
            wr_d_r <= link.transport_write_strobe_n;
            rd_d_r <= link.transport_read_strobe_n;
        end
    end

    // transmit assembly: in narrow mode the high byte comes first
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lo_half_r <= 1'b0;
            lo_byte_r <= 8'h00;
        end else if (!pipe_busy_r) begin
            lo_half_r <= 1'b0;
        end else if (!pipe_dir_rx_r && wr_edge && !wide_r) begin
            lo_half_r <= !lo_half_r;
            lo_byte_r <= link.transport_data_bus[7:0];
        end
    end

    assign txf_in = wide_r ? link.transport_data_bus
                           : {lo_byte_r, link.transport_data_bus[7:0]};
    assign txf_in_valid = pipe_busy_r && !pipe_dir_rx_r && wr_edge
                          && (wide_r || lo_half_r);

    adp_fifo #(.WIDTH(16), .DEPTH(LINK_DEPTH)) u_txf (
        .mclk(mclk),
        .reset_n(reset_n),
        .flush(!pipe_busy_r),
        .in_data(txf_in),
        .in_valid(txf_in_valid),
        .in_ready(txf_in_ready),
        .out_data(txf_out),
        .out_valid(txf_out_valid),
        .out_ready(pipe_tx_ready && pipe_tx_valid_r),
        .level()
    );

    // packetiser side sees registered copy; small lag traded for clean outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pipe_tx_word_r <= 16'h0000;
            pipe_tx_valid_r <= 1'b0;
        end else begin
            pipe_tx_word_r <= txf_out;
            pipe_tx_valid_r <= pipe_busy_r && txf_out_valid
                               && !(pipe_tx_ready && pipe_tx_valid_r);
        end
    end

    // payload words arrive header-free from the packet side
    adp_fifo #(.WIDTH(16), .DEPTH(LINK_DEPTH)) u_rxf (
        .mclk(mclk),
        .reset_n(reset_n),
        .flush(!pipe_busy_r),
        .in_data(pipe_rx_word),
        .in_valid(pipe_rx_valid && pipe_rx_ready_r),
        .in_ready(rxf_in_ready),
        .out_data(rxf_out),
        .out_valid(rxf_out_valid),
        .out_ready(rxf_pop),
        .level(rxf_level)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pipe_rx_ready_r <= 1'b0;
        end else begin
            // ready lags a cycle, so leave room for the word taken in this cycle
            pipe_rx_ready_r <= pipe_busy_r && pipe_dir_rx_r
                && (int'(rxf_level) + int'(pipe_rx_valid && pipe_rx_ready_r) < LINK_DEPTH);
        end
    end

    // narrow receive: high byte then low byte of one fifo word
    assign rxf_pop = pipe_busy_r && pipe_dir_rx_r && rd_edge && (wide_r || hi_pend_r);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hi_pend_r <= 1'b0;
        end else if (!pipe_busy_r) begin
            hi_pend_r <= 1'b0;
        end else if (pipe_dir_rx_r && rd_edge && !wide_r) begin
            hi_pend_r <= !hi_pend_r;
        end
    end

    always_comb begin
        rx_hi_r = rxf_out[15:8];
    end

    // drive the bus in the cycle after the peer's read strobe is sampled low
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dout_r <= 16'h0000;
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= !(pipe_busy_r && pipe_dir_rx_r && !link.transport_read_strobe_n);
            if (wide_r) begin
                dout_r <= rxf_out;
            end else begin
                dout_r <= {8'h00, hi_pend_r ? rxf_out[7:0] : rx_hi_r};
            end
        end
    end

    assign can_serve = pipe_dir_rx_r ? rxf_out_valid : txf_in_ready;

    // request pacing: every level lasts at least HALF cycles, except that the end of a run in ADP_PH_REQ drops the request at once
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= ADP_PH_IDLE;
            req_r <= 1'b0;
            pace_r <= 4'h0;
        end else begin
            if (pace_r != 4'h0) begin
                pace_r <= pace_r - 4'h1;
            end
            unique case (phase_r)
                ADP_PH_IDLE: begin
                    if (pipe_busy_r && can_serve && pace_r == 4'h0) begin
                        req_r <= 1'b1;
                        pace_r <= 4'(HALF);
                        phase_r <= ADP_PH_REQ;
                    end
                end
                ADP_PH_REQ: begin
                    if (!pipe_busy_r || (!can_serve && pace_r == 4'h0)) begin
                        req_r <= 1'b0;
                        pace_r <= 4'(HALF);
                        phase_r <= ADP_PH_IDLE;
                    end else if (!link.transport_request_ack_n) begin
                        phase_r <= ADP_PH_XFER;
                    end
                end
                ADP_PH_XFER: begin
                    if (wr_edge || rd_edge) begin
                        phase_r <= ADP_PH_HOLD;
                    end else if (link.transport_request_ack_n) begin
                        phase_r <= ADP_PH_REQ;
                    end
                end
                ADP_PH_HOLD: begin
                    if (link.transport_request_ack_n && pace_r == 4'h0) begin
                        req_r <= 1'b0;
                        pace_r <= 4'(HALF);
                        phase_r <= ADP_PH_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// file: verilog/adp_peer_port.sv
`timescale 1ns/100ps
`include "adp_consts.svh"
module adp_peer_port (
    input wire logic mclk,
    input wire logic reset_n,
    adp_link_if.peer link,
    input wire logic [15:0] src_word,
    input wire logic src_valid,
    output logic src_ready_r,
    output logic [15:0] sink_word_r,
    output logic sink_valid_r,
    input wire logic wide,
    input wire logic dir_rx
);
    import adp_pkg::*;
    adp_phase_type st_r;
    logic ack_n_r;
    logic wr_n_r;
    logic rd_n_r;
    logic oe_n_r;
    logic [15:0] dout_r;
    logic [1:0] step_r;
    logic [7:0] hi_byte_r;

    assign link.transport_request_ack_n = ack_n_r;
    assign link.transport_write_strobe_n = wr_n_r;
    assign link.transport_read_strobe_n = rd_n_r;
    assign link.peer_data_out = dout_r;
    assign link.peer_data_oe_n = oe_n_r;

    // one bus transfer per acknowledged request; narrow mode moves one byte
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ADP_PH_IDLE;
            ack_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            dout_r <= 16'h0000;
            src_ready_r <= 1'b0;
            sink_word_r <= 16'h0000;
            sink_valid_r <= 1'b0;
            step_r <= 2'b00;
            hi_byte_r <= 8'h00;
        end else begin
            src_ready_r <= 1'b0;
            sink_valid_r <= 1'b0;
            unique case (st_r)
                ADP_PH_IDLE: begin
                    if (link.transport_data_request && (dir_rx || src_valid)) begin
                        ack_n_r <= 1'b0;
                        st_r <= ADP_PH_REQ;
                    end
                end
                ADP_PH_REQ: begin
                    if (dir_rx) begin
                        rd_n_r <= 1'b0;
                    end else begin
                        wr_n_r <= 1'b0;
                        oe_n_r <= 1'b0;
                        dout_r <= wide ? src_word
                            : {8'h00, step_r[0] ? src_word[7:0] : src_word[15:8]};
                    end
                    st_r <= ADP_PH_XFER;
                end
                ADP_PH_XFER: begin
                    if (dir_rx) begin
                        rd_n_r <= 1'b1;
                    end else begin
                        wr_n_r <= 1'b1;
                        if (wide || step_r[0]) begin
                            src_ready_r <= 1'b1;
                        end
                        step_r <= wide ? 2'b00 : {1'b0, !step_r[0]};
                    end
                    st_r <= ADP_PH_HOLD;
                end
                ADP_PH_HOLD: begin
                    oe_n_r <= 1'b1;
                    ack_n_r <= 1'b1;
                    // device drives read data a cycle after the strobe falls; take it once here
                    if (dir_rx && !ack_n_r) begin
                        if (wide) begin
                            sink_valid_r <= 1'b1;
                            sink_word_r <= link.transport_data_bus;
                        end else if (step_r[0]) begin
                            sink_valid_r <= 1'b1;
                            sink_word_r <= {hi_byte_r, link.transport_data_bus[7:0]};
                        end else begin
                            hi_byte_r <= link.transport_data_bus[7:0];
                        end
                        step_r <= wide ? 2'b00 : {1'b0, !step_r[0]};
                    end
                    if (!link.transport_data_request) begin
                        st_r <= ADP_PH_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// file: tb/adp_link_props.sv
`timescale 1ns/100ps
module adp_link_props (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic dev_data_oe_n,
    input wire logic peer_data_oe_n,
    input wire logic transport_data_request,
    input wire logic transport_request_ack_n,
    input wire logic transport_write_strobe_n,
    input wire logic transport_read_strobe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_ack_req;
        !transport_request_ack_n |-> transport_data_request;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("ack low while request low");
    property p_ack_rel;
        $fell(transport_request_ack_n) |-> ##[1:8] transport_request_ack_n;
    endproperty
    a_ack_rel: assert property (p_ack_rel)
        else $error("ack not released in time");
    // two cycles per level keeps the request under its top rate
    property p_req_hi;
        $rose(transport_data_request) |=> transport_data_request;
    endproperty
    a_req_hi: assert property (p_req_hi)
        else $error("request high too short");
    property p_req_lo;
        $fell(transport_data_request) |=> !transport_data_request;
    endproperty
    a_req_lo: assert property (p_req_lo)
        else $error("request low too short");
    property p_no_clash;
        !dev_data_oe_n |-> peer_data_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive the data bus");
    property p_one_dir;
        transport_write_strobe_n || transport_read_strobe_n;
    endproperty
    a_one_dir: assert property (p_one_dir)
        else $error("both strobes low");
    property p_wr;
        $fell(transport_write_strobe_n) |-> !transport_request_ack_n ##1 transport_write_strobe_n;
    endproperty
    a_wr: assert property (p_wr)
        else $error("write strobe outside acknowledge");
    property p_rd;
        $fell(transport_read_strobe_n) |-> !transport_request_ack_n ##1 transport_read_strobe_n;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read strobe outside acknowledge");
endmodule

// file: tb/async_data_pipe_transport_port_tb_top.sv
`timescale 1ns/100ps
module async_data_pipe_transport_port_tb_top;
    logic mclk = 0, reset_n = 0, wsel = 1, start = 0, dir = 0, stop = 0;
    logic txr = 1, rxv = 0, srcv = 0, pw = 1, pd = 0;
    logic [15:0] rxw = 16'h0000, srcw = 16'h0000;
    logic busy, dir_r, txv, rxr, wide_r, src_rdy, snk_v;
    logic [15:0] txw, snk_w;
    logic [15:0] got[$];
    int n_fail = 0, num_checks = 0, cyc = 0, nstb = 0, k;
    always #20 mclk = ~mclk;
    adp_link_if link ();
    adp_device_port u_adp_device_port (.mclk(mclk), .reset_n(reset_n), .link(link),
        .transport_width_wide_select(wsel), .pipe_start(start), .pipe_dir_rx(dir),
        .pipe_stop(stop), .pipe_busy_r(busy), .pipe_dir_rx_r(dir_r), .pipe_tx_word_r(txw),
        .pipe_tx_valid_r(txv), .pipe_tx_ready(txr), .pipe_rx_word(rxw), .pipe_rx_valid(rxv),
        .pipe_rx_ready_r(rxr), .wide_r(wide_r));
    adp_peer_port u_adp_peer_port (.mclk(mclk), .reset_n(reset_n), .link(link),
        .src_word(srcw), .src_valid(srcv), .src_ready_r(src_rdy), .sink_word_r(snk_w),
        .sink_valid_r(snk_v), .wide(pw), .dir_rx(pd));
    adp_link_props u_adp_link_props (.mclk(mclk), .reset_n(reset_n),
        .dev_data_oe_n(link.dev_data_oe_n), .peer_data_oe_n(link.peer_data_oe_n),
        .transport_data_request(link.transport_data_request),
        .transport_request_ack_n(link.transport_request_ack_n),
        .transport_write_strobe_n(link.transport_write_strobe_n),
        .transport_read_strobe_n(link.transport_read_strobe_n));
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (txv === 1'b1 && txr === 1'b1) got.push_back(txw);
        if (snk_v === 1'b1) got.push_back(snk_w);
        // each strobe is low for one cycle, so low samples count transfers
        if (link.transport_write_strobe_n === 1'b0 || link.transport_read_strobe_n === 1'b0) nstb++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic run(input logic d, input logic w);
        {dir, wsel, pd, pw, start} = {d, w, d, w, 1'b1};
        nstb = 0;
        tick(1);
        start = 0;
    endtask
    task automatic end_run();
        stop = 1;
        tick(1);
        stop = 0;
        tick(3);
        chk("busy", 16'h0000, {15'h0000, busy});
    endtask
    task automatic tx_words(input int n, input logic [15:0] b);
        for (int j = 0; j < n; j++) begin
            srcw = b + j[15:0];
            srcv = 1;
            tick(1);
            for (int i = 0; i < 400 && src_rdy !== 1'b1; i++) @(negedge mclk);
        end
        srcv = 0;
    endtask
    task automatic rx_words(input int n, input logic [15:0] b);
        for (int j = 0; j < n; j++) begin
            rxw = b + j[15:0];
            rxv = 1;
            for (int i = 0; i < 400 && rxr !== 1'b1; i++) @(negedge mclk);
            tick(1);
        end
        rxv = 0;
    endtask
    task automatic cmp(input int n, input logic [15:0] b);
        chk("word count", n[15:0], 16'(got.size()));
        for (int i = 0; i < got.size(); i++) chk("word", b + i[15:0], got[i]);
        got.delete();
    endtask
    initial begin
        tick(5);
        reset_n = 1;
        chk("wide after reset", 16'h0001, {15'h0000, wide_r});
        chk("request after reset", 16'h0000, {15'h0000, link.transport_data_request});
        $display("test reset done");
        for (int d = 0; d < 2; d++) begin
            for (int w = 0; w < 2; w++) begin
                run(d[0], w[0]);
                if (d == 0) tx_words(4, 16'h1a00 + d[15:0] * 16'h0100);
                else rx_words(4, 16'h1a00 + d[15:0] * 16'h0100);
                // narrow receive needs eight paced transfers after the words are queued
                tick(100);
                cmp(4, 16'h1a00 + d[15:0] * 16'h0100);
                chk("strobes", (w ? 16'h0004 : 16'h0008), nstb[15:0]);
                end_run();
            end
        end
        $display("test directions and widths done");
        run(0, 1);
        txr = 0;
        fork
            tx_words(8, 16'h5c00);
        join_none
        tick(150);
        chk("request while full", 16'h0000, {15'h0000, link.transport_data_request});
        chk("words while stalled", 16'h0000, 16'(got.size()));
        {dir, wsel, start} = 3'b101;
        tick(1);
        start = 0;
        tick(2);
        chk("direction held", 16'h0000, {15'h0000, dir_r});
        chk("width held", 16'h0001, {15'h0000, wide_r});
        txr = 1;
        wait fork;
        tick(60);
        cmp(8, 16'h5c00);
        end_run();
        $display("test stall done");
        // link fifo seen through the device: packet side stalled, count words absorbed
        run(0, 1);
        txr = 0;
        k = 0;
        srcw = 16'h0f00;
        srcv = 1;
        repeat (120) begin
            tick(1);
            if (src_rdy === 1'b1) begin
                k++;
                srcw = 16'h0f00 + k[15:0];
            end
        end
        srcv = 0;
        chk("fifo fill", 16'h0004, k[15:0]);
        chk("fifo head", 16'h0f00, txv === 1'b1 ? txw : 16'hffff);
        txr = 1;
        tick(20);
        cmp(4, 16'h0f00);
        chk("fifo empty", 16'h0000, {15'h0000, txv});
        chk("request with room", 16'h0001, {15'h0000, link.transport_data_request});
        end_run();
        $display("test fifo done");
        conclude();
    end
endmodule
